/* File: mtp_core.sv */
/*
 * mtp_core.sv
 * server address mapper, idle connection watchdog and client command
 * pacing for the tcp register protocol unit.
 * assumes the stack supplies decoded requests, and that the register port
 * master never waits and never raises both strobes at once.
 */
// Operation
// - float enabled: holding reads and writes use the float window.
// - register at or above float start is a float request.
// - first float register maps to database word float base.
// - client float register takes two words from float base.
// - float start and base ignored while float is disabled.
// - coil address zero maps to bit 0 of coil base word.
// - discrete inputs add the discrete-input base word.
// - holding accesses add the holding base word.
// - input registers add the input-word base.
// - close a connection idle for the configured seconds.
// - wait the inter-command gap before each new command.
// - retries go out at once, with no gap.
// - retransmit when no reply arrives within the reply wait.
// - retry a failed command at most the retry limit.
// - client float start accepts up to 32767.
// - wait up to the configured seconds for address resolution.
// - suspend a failed command for count times 100 ms; zero skips.
`include "mtp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mtp_core
	import mtp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// server request in
	input wire logic req_valid,
	input wire logic [2:0] req_kind,
	input wire logic [15:0] req_addr,
	// server mapped address out
	output logic map_valid,
	output logic [15:0] map_word,
	output logic map_float,
	output logic map_error,
	// server connection activity
	input wire logic conn_open,
	input wire logic conn_rx,
	output logic conn_close,
	// client command port
	input wire logic cmd_start,
	input wire logic [15:0] cmd_addr,
	input wire logic cmd_resolved,
	input wire logic arw_reply,
	input wire logic cmd_reply,
	input wire logic cmd_bad,
	output logic arw_request,
	output logic cmd_send,
	output logic cmd_is_retry,
	output logic [15:0] cmd_word,
	output logic cmd_done,
	output logic cmd_fail,
	output logic cli_busy,
	// interrupt
	output logic irq
);

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic flt_en;
	logic [15:0] flt_start;
	logic [11:0] flt_base;
	logic [11:0] coil_base;
	logic [11:0] din_base;
	logic [11:0] hold_base;
	logic [11:0] iword_base;
	logic [10:0] idle_s;
	logic [15:0] cmd_gap;
	logic [15:0] reply_wait;
	logic [3:0] retry_max;
	logic cflt_en;
	logic [15:0] cflt_start;
	logic [11:0] cflt_base;
	logic [5:0] arw_s;
	logic [8:0] err_hold;
	logic [`MTP_IRQ_W-1:0] irq_stat;
	logic [`MTP_IRQ_W-1:0] irq_mask;
	logic [`MTP_IRQ_W-1:0] irq_set;
	mtp_state_e state;
	logic [3:0] retries;

	// software writes, out-of-range values saturate at the documented top (arw_s also at its minimum)
	always_ff @(posedge clk) begin
		if (reset) begin
			flt_en <= 1'b0;
			flt_start <= 16'h0000;
			flt_base <= 12'h000;
			coil_base <= 12'h000;
			din_base <= 12'h000;
			hold_base <= 12'h000;
			iword_base <= 12'h000;
			idle_s <= 11'h000;
			cmd_gap <= 16'h0000;
			reply_wait <= 16'h0000;
			retry_max <= 4'h0;
			cflt_en <= 1'b0;
			cflt_start <= 16'h0000;
			cflt_base <= 12'h000;
			arw_s <= `MTP_ARW_MIN;
			err_hold <= 9'h000;
			irq_mask <= '0;
		end else if (reg_write) begin
			case (reg_addr)
				`MTP_REG_SRV_CFG: flt_en <= reg_wdata[0];
				`MTP_REG_FLT_START: flt_start <= reg_wdata[15:0];
				`MTP_REG_FLT_BASE: flt_base <= sat12(reg_wdata[15:0], `MTP_BASE_MAX);
				`MTP_REG_COIL_BASE: coil_base <= sat12(reg_wdata[15:0], `MTP_BASE_MAX);
				`MTP_REG_DIN_BASE: din_base <= sat12(reg_wdata[15:0], `MTP_BASE_MAX);
				`MTP_REG_HOLD_BASE: hold_base <= sat12(reg_wdata[15:0], `MTP_BASE_MAX);
				`MTP_REG_IWORD_BASE: iword_base <= sat12(reg_wdata[15:0], `MTP_BASE_MAX);
				`MTP_REG_IDLE_S: idle_s <= (reg_wdata[15:0] > 16'(`MTP_IDLE_MAX)) ?
					`MTP_IDLE_MAX : reg_wdata[10:0];
				`MTP_REG_CMD_GAP: cmd_gap <= (reg_wdata[15:0] > `MTP_GAP_MAX) ?
					`MTP_GAP_MAX : reg_wdata[15:0];
				`MTP_REG_REPLY_WAIT: reply_wait <= reg_wdata[15:0];
				`MTP_REG_RETRY_MAX: retry_max <= (reg_wdata[15:0] > 16'(`MTP_RETRY_MAX)) ?
					`MTP_RETRY_MAX : reg_wdata[3:0];
				`MTP_REG_CLI_CFG: cflt_en <= reg_wdata[0];
				`MTP_REG_CFLT_START: cflt_start <= (reg_wdata[15:0] > `MTP_CFLT_MAX) ?
					`MTP_CFLT_MAX : reg_wdata[15:0];
				`MTP_REG_CFLT_BASE: cflt_base <= sat12(reg_wdata[15:0], `MTP_CBASE_MAX);
				`MTP_REG_ARW_S: arw_s <= (reg_wdata[15:0] > 16'(`MTP_ARW_MAX)) ? `MTP_ARW_MAX :
					(reg_wdata[15:0] < 16'(`MTP_ARW_MIN)) ? `MTP_ARW_MIN : reg_wdata[5:0];
				`MTP_REG_ERR_HOLD: err_hold <= (reg_wdata[15:0] > 16'(`MTP_ERRH_MAX)) ?
					`MTP_ERRH_MAX : reg_wdata[8:0];
				`MTP_REG_IRQ_MASK: irq_mask <= reg_wdata[`MTP_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// clamp helper for the 0..3999 style fields
	function automatic logic [11:0] sat12(input logic [15:0] v, input logic [11:0] top);
		sat12 = (v > {4'h0, top}) ? top : v[11:0];
	endfunction

	// read data one cycle after the strobe, zero otherwise and when unmapped
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			case (reg_addr)
				`MTP_REG_SRV_CFG: reg_rdata <= {31'h0, flt_en};
				`MTP_REG_FLT_START: reg_rdata <= {16'h0, flt_start};
				`MTP_REG_FLT_BASE: reg_rdata <= {20'h0, flt_base};
				`MTP_REG_COIL_BASE: reg_rdata <= {20'h0, coil_base};
				`MTP_REG_DIN_BASE: reg_rdata <= {20'h0, din_base};
				`MTP_REG_HOLD_BASE: reg_rdata <= {20'h0, hold_base};
				`MTP_REG_IWORD_BASE: reg_rdata <= {20'h0, iword_base};
				`MTP_REG_IDLE_S: reg_rdata <= {21'h0, idle_s};
				`MTP_REG_CMD_GAP: reg_rdata <= {16'h0, cmd_gap};
				`MTP_REG_REPLY_WAIT: reg_rdata <= {16'h0, reply_wait};
				`MTP_REG_RETRY_MAX: reg_rdata <= {28'h0, retry_max};
				`MTP_REG_CLI_CFG: reg_rdata <= {31'h0, cflt_en};
				`MTP_REG_CFLT_START: reg_rdata <= {16'h0, cflt_start};
				`MTP_REG_CFLT_BASE: reg_rdata <= {20'h0, cflt_base};
				`MTP_REG_ARW_S: reg_rdata <= {26'h0, arw_s};
				`MTP_REG_ERR_HOLD: reg_rdata <= {23'h0, err_hold};
				`MTP_REG_CLI_STAT: reg_rdata <= {22'h0, retries, state};
				`MTP_REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat};
				`MTP_REG_IRQ_MASK: reg_rdata <= {28'h0, irq_mask};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// tick base
	// ************************************************************
	logic [17:0] ms_div;
	logic ms_tick;
	logic [6:0] tenth_div;
	logic tenth_tick;
	logic [9:0] sec_div;
	logic sec_tick;

	// one free-running chain gives ms, 100 ms and s enables
	always_ff @(posedge clk) begin
		if (reset) begin
			ms_div <= 18'h0_0000;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_div == 18'(`MTP_MS_CYCLES - 1));
			ms_div <= (ms_div == 18'(`MTP_MS_CYCLES - 1)) ? 18'h0_0000 : ms_div + 18'h0_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tenth_div <= 7'h00;
			sec_div <= 10'h000;
		end else if (ms_tick) begin
			tenth_div <= (tenth_div == 7'(`MTP_TENTHS_PER_MS - 1)) ? 7'h00 : tenth_div + 7'h01;
			sec_div <= (sec_div == 10'(`MTP_MS_PER_S - 1)) ? 10'h000 : sec_div + 10'h001;
		end
	end

	assign tenth_tick = ms_tick && (tenth_div == 7'(`MTP_TENTHS_PER_MS - 1));
	assign sec_tick = ms_tick && (sec_div == 10'(`MTP_MS_PER_S - 1));

	// ************************************************************
	// server address mapper
	// ************************************************************
	logic [16:0] map_sum;
	logic is_float;

	// holding accesses switch to the float window only when enabled
	always_comb begin
		is_float = flt_en && (req_kind == MTP_FC_HOLD) && (req_addr >= flt_start);
		case (mtp_kind_e'(req_kind))
			MTP_FC_COIL: map_sum = {5'h0, coil_base} + {5'h0, req_addr[15:4]};
			MTP_FC_DIN: map_sum = {5'h0, din_base} + {1'b0, req_addr};
			MTP_FC_HOLD: map_sum = is_float ?
				{5'h0, flt_base} + {1'b0, req_addr - flt_start} :
				{5'h0, hold_base} + {1'b0, req_addr};
			MTP_FC_IWORD: map_sum = {5'h0, iword_base} + {1'b0, req_addr};
			default: map_sum = 17'h1_ffff;
		endcase
	end

	// coils keep the bit index in the low nibble of the word address' partner
	always_ff @(posedge clk) begin
		if (reset) begin
			map_valid <= 1'b0;
			map_word <= 16'h0000;
			map_float <= 1'b0;
			map_error <= 1'b0;
		end else begin
			map_valid <= req_valid;
			map_word <= map_sum[15:0];
			map_float <= req_valid && is_float;
			map_error <= req_valid && (map_sum > 17'({5'h0, `MTP_BASE_MAX}));
		end
	end

	// ************************************************************
	// idle connection watchdog
	// ************************************************************
	logic [10:0] idle_cnt;

	// zero idle time disables closing; any received data restarts the count
	always_ff @(posedge clk) begin
		if (reset || !conn_open || conn_rx) begin
			idle_cnt <= 11'h000;
			conn_close <= 1'b0;
		end else begin
			conn_close <= 1'b0;
			if (sec_tick && idle_s != 11'h000) begin
				if (idle_cnt + 11'h001 >= idle_s) begin
					conn_close <= 1'b1;
					idle_cnt <= 11'h000;
				end else begin
					idle_cnt <= idle_cnt + 11'h001;
				end
			end
		end
	end

	// ************************************************************
	// client command pacing
	// ************************************************************
	logic [15:0] cnt;
	logic [15:0] word_off;

	// client float registers take two words each
	assign word_off = cmd_addr - cflt_start;
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_word <= 16'h0000;
		end else if (cmd_start && state == MTP_ST_IDLE) begin
			cmd_word <= (cflt_en && cmd_addr >= cflt_start) ?
				16'({4'h0, cflt_base}) + {word_off[14:0], 1'b0} : cmd_addr;
		end
	end

	// the sequencer; the counter counts in units set by the state
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= MTP_ST_IDLE;
			cnt <= 16'h0000;
			retries <= 4'h0;
			arw_request <= 1'b0;
			cmd_send <= 1'b0;
			cmd_is_retry <= 1'b0;
			cmd_done <= 1'b0;
			cmd_fail <= 1'b0;
		end else begin
			arw_request <= 1'b0;
			cmd_send <= 1'b0;
			cmd_done <= 1'b0;
			cmd_fail <= 1'b0;
			case (state)
				MTP_ST_IDLE: if (cmd_start) begin
					retries <= 4'h0;
					cmd_is_retry <= 1'b0;
					cnt <= 16'h0000;
					state <= MTP_ST_GAP;
				end
				MTP_ST_GAP: if (cnt >= cmd_gap) begin
					cnt <= 16'h0000;
					state <= cmd_resolved ? MTP_ST_SEND : MTP_ST_ARW;
					arw_request <= !cmd_resolved;
				end else if (ms_tick) begin
					cnt <= cnt + 16'h0001;
				end
				MTP_ST_ARW: if (arw_reply) begin
					cnt <= 16'h0000;
					state <= MTP_ST_SEND;
				end else if (cnt >= 16'(arw_s)) begin
					cnt <= 16'h0000;
					state <= MTP_ST_HOLD;
					cmd_fail <= 1'b1;
				end else if (sec_tick) begin
					cnt <= cnt + 16'h0001;
				end
				MTP_ST_SEND: begin
					cmd_send <= 1'b1;
					cnt <= 16'h0000;
					state <= MTP_ST_WAIT;
				end
				MTP_ST_WAIT: if (cmd_reply && !cmd_bad) begin
					cmd_done <= 1'b1;
					cmd_is_retry <= 1'b0;
					state <= MTP_ST_IDLE;
				end else if (cmd_bad || cnt >= reply_wait) begin
					cnt <= 16'h0000;
					if (retries < retry_max) begin
						retries <= retries + 4'h1;
						cmd_is_retry <= 1'b1;
						state <= MTP_ST_SEND;
					end else begin
						cmd_fail <= 1'b1;
						state <= MTP_ST_HOLD;
					end
				end else if (ms_tick) begin
					cnt <= cnt + 16'h0001;
				end
				MTP_ST_HOLD: if (cnt >= 16'(err_hold)) begin
					cmd_is_retry <= 1'b0;
					state <= MTP_ST_IDLE;
				end else if (tenth_tick) begin
					cnt <= cnt + 16'h0001;
				end
				default: state <= MTP_ST_IDLE;
			endcase
		end
	end

	assign cli_busy = (state != MTP_ST_IDLE);

	// ************************************************************
	// interrupts
	// ************************************************************
	assign irq_set = {arw_request, cmd_fail, cmd_done, conn_close};

	// a new event beats a write-one-to-clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat <= '0;
		end else if (reg_write && reg_addr == `MTP_REG_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~reg_wdata[`MTP_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	assign irq = |(irq_stat & irq_mask);

endmodule // mtp_core

`default_nettype wire

/* File: mtp_core_sva.sv */
/* mtp_core_sva.sv: port timing checks for the map and poll block.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
`default_nettype none
module mtp_core_sva
	import mtp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// server side
	input wire logic req_valid,
	input wire logic [2:0] req_kind,
	input wire logic map_valid,
	input wire logic map_float,
	input wire logic map_error,
	input wire logic conn_open,
	input wire logic conn_rx,
	input wire logic conn_close,
	// client side
	input wire logic cmd_start,
	input wire logic cmd_reply,
	input wire logic cmd_bad,
	input wire logic cmd_send,
	input wire logic cmd_is_retry,
	input wire logic cmd_done,
	input wire logic cmd_fail,
	input wire logic cli_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ****************
	// server checks
	// ****************
	property p_map_lat; req_valid |=> map_valid; endproperty
	a_map_lat: assert property (p_map_lat)
		else $error("map result missing");
	property p_map_quiet; !req_valid |=> !map_valid; endproperty
	a_map_quiet: assert property (p_map_quiet)
		else $error("map result without request");
	property p_bad_kind; req_valid && req_kind > 3'h3 |=> map_error; endproperty
	a_bad_kind: assert property (p_bad_kind)
		else $error("invalid kind not flagged");
	property p_float_hold; map_float |-> map_valid && $past(req_kind) == MTP_FC_HOLD; endproperty
	a_float_hold: assert property (p_float_hold)
		else $error("float flag on non holding access");
	property p_close_idle; conn_close |-> $past(conn_open) && !$past(conn_rx); endproperty
	a_close_idle: assert property (p_close_idle)
		else $error("close on active connection");
	// ****************
	// client checks
	// ****************
	property p_start_busy; cmd_start && !cli_busy |=> cli_busy; endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("command not taken");
	property p_send_busy; cmd_send |-> cli_busy; endproperty
	a_send_busy: assert property (p_send_busy)
		else $error("send while idle");
	property p_done_cause; cmd_done |-> $past(cmd_reply) && !$past(cmd_bad); endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done without good reply");
	property p_retry_busy; cmd_is_retry |-> cli_busy; endproperty
	a_retry_busy: assert property (p_retry_busy)
		else $error("retry flag while idle");
	property p_fail_pulse; cmd_fail |=> !cmd_fail && !cmd_done; endproperty
	a_fail_pulse: assert property (p_fail_pulse)
		else $error("fail not a single pulse");
endmodule // mtp_core_sva
bind mtp_core mtp_core_sva u_sva (.clk, .reset, .req_valid, .req_kind, .map_valid,
	.map_float, .map_error, .conn_open, .conn_rx, .conn_close, .cmd_start, .cmd_reply,
	.cmd_bad, .cmd_send, .cmd_is_retry, .cmd_done, .cmd_fail, .cli_busy);
`default_nettype wire

/* File: mtp_core_tb_top.sv */
/* mtp_core_tb_top.sv: self-checking bench for the map and poll block.
   assumes float enable is bit 0 of both config registers; long timers
   are kept at zero or one so that no run waits on a second tick. */
`include "mtp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mtp_core_tb_top;
	import mtp_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'b0, reg_read = 1'b0, req_valid = 1'b0;
	logic [2:0] req_kind = 3'h0;
	logic [15:0] req_addr = 16'h0000, cmd_addr = 16'h0000;
	logic conn_open = 1'b0, conn_rx = 1'b0, cmd_start = 1'b0, cmd_resolved = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [31:0] reg_rdata;
	logic [15:0] map_word, cmd_word, last_word;
	logic map_valid, map_float, map_error, conn_close, arw_reply, cmd_reply, cmd_bad;
	logic arw_request, cmd_send, cmd_is_retry, cmd_done, cmd_fail, cli_busy, irq;
	int err_count = 0, n_compared = 0, n_send = 0, n_ret = 0, n_fail = 0, n_end = 0, n_arw = 0;

	mtp_core DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.req_valid, .req_kind, .req_addr, .map_valid, .map_word, .map_float, .map_error,
		.conn_open, .conn_rx, .conn_close, .cmd_start, .cmd_addr, .cmd_resolved,
		.arw_reply, .cmd_reply, .cmd_bad, .arw_request, .cmd_send, .cmd_is_retry,
		.cmd_word, .cmd_done, .cmd_fail, .cli_busy, .irq);
	mtp_peer u_peer (.clk, .reset, .mode, .dly(4'h2), .arw_request, .cmd_send,
		.arw_reply, .cmd_reply, .cmd_bad);

	initial begin
		forever #2.5 clk = ~clk;
	end
	// pulse counters; a retry is a send with the retry flag up
	always @(posedge clk) begin
		if (cmd_send) n_send <= n_send + 1;
		if (cmd_send) last_word <= cmd_word;
		if (cmd_send && cmd_is_retry) n_ret <= n_ret + 1;
		if (cmd_fail) n_fail <= n_fail + 1;
		if (cmd_done || cmd_fail) n_end <= n_end + 1;
		if (arw_request) n_arw <= n_arw + 1;
	end

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic req(input logic [2:0] k, input logic [15:0] a, input logic [15:0] w,
		input logic f, input logic e);
		@(posedge clk);
		req_kind <= k;
		req_addr <= a;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		#1 chk(map_error, e);
		if (!e) chk(map_word, w);
		if (!e) chk(map_float, f);
	endtask
	// start one command and judge its whole life
	task automatic run_cmd(input logic [15:0] a, input logic res, input logic [1:0] m,
		input int es, input int er, input int ef);
		int s0 = n_send, r0 = n_ret, f0 = n_fail, e0 = n_end;
		@(posedge clk);
		cmd_addr <= a;
		cmd_resolved <= res;
		mode <= m;
		cmd_start <= 1'b1;
		@(posedge clk);
		cmd_start <= 1'b0;
		for (int i = 0; i < 5000 && n_end == e0; i++) @(posedge clk);
		if (n_end == e0) begin
			err_count++;
			$display("unexpected %0t command never ended", $time);
			end_sim();
		end
		#1 chk(n_send - s0, es);
		chk(n_ret - r0, er);
		chk(n_fail - f0, ef);
	endtask

	// limits clamp, unmapped reads give zero
	task automatic t_regs();
		wr(`MTP_REG_CMD_GAP, 32'h0000_9c40);
		rd(`MTP_REG_CMD_GAP, 32'h0000_7fff);
		wr(`MTP_REG_RETRY_MAX, 32'h0000_000f);
		rd(`MTP_REG_RETRY_MAX, 32'h0000_000a);
		wr(`MTP_REG_ERR_HOLD, 32'h0000_0190);
		rd(`MTP_REG_ERR_HOLD, 32'h0000_012c);
		wr(`MTP_REG_CFLT_START, 32'h0000_9c40);
		rd(`MTP_REG_CFLT_START, 32'h0000_7fff);
		rd(8'h80, 32'h0000_0000);
		$display("test regs done");
	endtask
	task automatic t_map();
		conn_open <= 1'b1;
		wr(`MTP_REG_COIL_BASE, 32'h0000_0032);
		wr(`MTP_REG_DIN_BASE, 32'h0000_0096);
		wr(`MTP_REG_HOLD_BASE, 32'h0000_003c);
		wr(`MTP_REG_IWORD_BASE, 32'h0000_00c8);
		wr(`MTP_REG_FLT_START, 32'h0000_0bb8);
		wr(`MTP_REG_FLT_BASE, 32'h0000_000a);
		req(MTP_FC_COIL, 16'h0023, 16'h0034, 1'b0, 1'b0);
		req(MTP_FC_DIN, 16'h0003, 16'h0099, 1'b0, 1'b0);
		req(MTP_FC_HOLD, 16'h000a, 16'h0046, 1'b0, 1'b0);
		req(MTP_FC_IWORD, 16'h0000, 16'h00c8, 1'b0, 1'b0);
		req(3'h5, 16'h0000, 16'h0000, 1'b0, 1'b1);
		req(MTP_FC_HOLD, 16'h0bb8, 16'h0bf4, 1'b0, 1'b0);
		conn_rx <= 1'b1;
		wr(`MTP_REG_SRV_CFG, 32'h0000_0001);
		conn_rx <= 1'b0;
		req(MTP_FC_HOLD, 16'h0bbd, 16'h000f, 1'b1, 1'b0);
		req(MTP_FC_HOLD, 16'h0bb7, 16'h0bf3, 1'b0, 1'b0);
		req(MTP_FC_COIL, 16'h0010, 16'h0033, 1'b0, 1'b0);
		#1 chk(conn_close, 1'b0);
		conn_open <= 1'b0;
		$display("test map done");
	endtask
	// good reply, float word, then done interrupt
	task automatic t_ok();
		wr(`MTP_REG_CLI_CFG, 32'h0000_0001);
		wr(`MTP_REG_CFLT_START, 32'h0000_0064);
		wr(`MTP_REG_CFLT_BASE, 32'h0000_000a);
		wr(`MTP_REG_CMD_GAP, 32'h0000_0000);
		wr(`MTP_REG_REPLY_WAIT, 32'h0000_0001);
		wr(`MTP_REG_RETRY_MAX, 32'h0000_0002);
		wr(`MTP_REG_ERR_HOLD, 32'h0000_0000);
		wr(`MTP_REG_IRQ_MASK, 32'h0000_000f);
		run_cmd(16'h0067, 1'b1, 2'h0, 1, 0, 0);
		chk(last_word, 16'h0010);
		chk(irq, 1'b1);
		rd(`MTP_REG_IRQ_STAT, 32'h0000_0002);
		wr(`MTP_REG_IRQ_STAT, 32'h0000_0002);
		#1 chk(irq, 1'b0);
		$display("test ok done");
	endtask
	// silent peer: retries go out at once, then failure
	task automatic t_timeout();
		wr(`MTP_REG_REPLY_WAIT, 32'h0000_0000);
		run_cmd(16'h0005, 1'b1, 2'h1, 3, 2, 1);
		rd(`MTP_REG_IRQ_STAT, 32'h0000_0004);
		wr(`MTP_REG_IRQ_MASK, 32'h0000_0000);
		#1 chk(irq, 1'b0);
		wr(`MTP_REG_IRQ_STAT, 32'h0000_000f);
		wr(`MTP_REG_IRQ_MASK, 32'h0000_000f);
		$display("test timeout done");
	endtask
	// error replies with one retry, then address resolution first
	task automatic t_bad_arw();
		int a0 = n_arw;
		wr(`MTP_REG_REPLY_WAIT, 32'h0000_0001);
		wr(`MTP_REG_RETRY_MAX, 32'h0000_0001);
		run_cmd(16'h0005, 1'b1, 2'h2, 2, 1, 1);
		run_cmd(16'h0005, 1'b0, 2'h0, 1, 0, 0);
		chk(n_arw - a0, 1);
		$display("test bad and resolve done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_map();
		t_ok();
		t_timeout();
		t_bad_arw();
		end_sim();
	end
endmodule // mtp_core_tb_top
`default_nettype wire

/* File: mtp_params.svh */
/*
 * mtp_params.svh
 * holds offsets, field positions, reset values and timing counts for the
 * register-protocol map and poll timing block.
 * assumes a 200 MHz clock and a one-cycle register port.
 */
`ifndef MTP_PARAMS_SVH
`define MTP_PARAMS_SVH

// ************************************************************
// clock and time bases
// ************************************************************
`define MTP_CLK_HZ 200000000
`define MTP_MS_NS 1000000
`define MTP_CLK_NS 5
`define MTP_MS_CYCLES (`MTP_MS_NS / `MTP_CLK_NS)
`define MTP_TENTHS_PER_MS 100
`define MTP_MS_PER_S 1000

// ************************************************************
// register offsets
// ************************************************************
`define MTP_REG_SRV_CFG 8'h00
`define MTP_REG_FLT_START 8'h04
`define MTP_REG_FLT_BASE 8'h08
`define MTP_REG_COIL_BASE 8'h0c
`define MTP_REG_DIN_BASE 8'h10
`define MTP_REG_HOLD_BASE 8'h14
`define MTP_REG_IWORD_BASE 8'h18
`define MTP_REG_IDLE_S 8'h1c
`define MTP_REG_CMD_GAP 8'h20
`define MTP_REG_REPLY_WAIT 8'h24
`define MTP_REG_RETRY_MAX 8'h28
`define MTP_REG_CLI_CFG 8'h2c
`define MTP_REG_CFLT_START 8'h30
`define MTP_REG_CFLT_BASE 8'h34
`define MTP_REG_ARW_S 8'h38
`define MTP_REG_ERR_HOLD 8'h3c
`define MTP_REG_CLI_STAT 8'h40
`define MTP_REG_IRQ_STAT 8'h44
`define MTP_REG_IRQ_MASK 8'h48

// ************************************************************
// limits and reset values
// ************************************************************
`define MTP_BASE_MAX 12'd3999
`define MTP_CBASE_MAX 12'd3998
`define MTP_IDLE_MAX 11'd1200
`define MTP_GAP_MAX 16'd32767
`define MTP_RETRY_MAX 4'd10
`define MTP_ARW_MAX 6'd60
`define MTP_ARW_MIN 6'd1
`define MTP_ERRH_MAX 9'd300
`define MTP_CFLT_MAX 16'd32767

// ************************************************************
// interrupt status bits
// ************************************************************
`define MTP_IRQ_IDLE 0
`define MTP_IRQ_DONE 1
`define MTP_IRQ_FAIL 2
`define MTP_IRQ_ARW 3
`define MTP_IRQ_W 4

`endif

/* File: mtp_peer.sv */
/* mtp_peer.sv: remote server model that answers client commands and
   address resolution requests.
   assumes one clock, a sync active high reset and dly of at least 1. */
`timescale 1ns/1ps
`default_nettype none
module mtp_peer (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// behaviour: 0 good reply, 1 silent, 2 error reply
	input wire logic [1:0] mode,
	input wire logic [3:0] dly,
	// client side
	input wire logic arw_request,
	input wire logic cmd_send,
	output logic arw_reply,
	output logic cmd_reply,
	output logic cmd_bad
);
	logic [3:0] cnt;
	logic [3:0] acnt;
	// command reply after dly cycles; a silent peer never answers
	always_ff @(posedge clk) begin
		cmd_reply <= 1'b0;
		cmd_bad <= 1'b0;
		if (reset) begin
			cnt <= 4'h0;
		end else if (cmd_send && mode != 2'h1) begin
			cnt <= dly;
		end else if (cnt == 4'h1) begin
			cmd_reply <= 1'b1;
			cmd_bad <= (mode == 2'h2);
			cnt <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	// address replies after the same delay
	always_ff @(posedge clk) begin
		arw_reply <= 1'b0;
		if (reset) begin
			acnt <= 4'h0;
		end else if (arw_request) begin
			acnt <= dly;
		end else if (acnt != 4'h0) begin
			arw_reply <= (acnt == 4'h1);
			acnt <= acnt - 4'h1;
		end
	end
endmodule // mtp_peer
`default_nettype wire

/* File: mtp_pkg.sv */
/*
 * mtp_pkg.sv
 * types shared by the map and poll timing block.
 * assumes mtp_params.svh supplies the numbers.
 */
package mtp_pkg;
	// request kinds as seen by the server mapper
	typedef enum logic [2:0] {
		MTP_FC_COIL = 3'h0,
		MTP_FC_DIN = 3'h1,
		MTP_FC_HOLD = 3'h2,
		MTP_FC_IWORD = 3'h3,
		MTP_FC_NONE = 3'h7
	} mtp_kind_e;

	// client poll sequencer states
	typedef enum logic [5:0] {
		MTP_ST_IDLE = 6'b000001,
		MTP_ST_GAP = 6'b000010,
		MTP_ST_ARW = 6'b000100,
		MTP_ST_SEND = 6'b001000,
		MTP_ST_WAIT = 6'b010000,
		MTP_ST_HOLD = 6'b100000
	} mtp_state_e;
endpackage
